/* File: design/fault_shutdown_params.svh */
// Constants for the fault shutdown and blanking controller
// Overview of operation
// - Blank each bridge at reversal and after each chop, every eight clocks.
// - Select bits one,zero give a blanking interval of three clocks.
// - Select bits zero,one give six clocks; bridges C,D own a pair.
// - Release converters above upper threshold, shut off below lower one.
// - Falling between thresholds, converter voltage supervisor is ignored.
// - Latched motor shutdown clears on power-down, sleep rising edge, all-clear or supply below lower threshold.
// - Reset output low period after all-clear or motor fault lasts 40 ms; the high level is not timed.
// - Fault responses apply only while all protection control bits are zero.
// - Motor overcurrent stops bridges only, converters run, one reset pulse.
// - Motor-off fault holds until host toggles sleep or sends all-clear, power-down is asserted or supply drops below lower threshold.
// - Converter fault or overheating stops everything, reset low until all-clear.
// - No fault and sleep low: bridges off, converters on, reset high.
// - All-clear stops everything, restores defaults, then repeats start-up.
// - All-clear is deglitched 2.5 to 7.5 us; high counts as asserted.
`ifndef FAULT_SHUTDOWN_PARAMS_SVH
`define FAULT_SHUTDOWN_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define RST_PERIOD_MS 40
`define RST_PERIOD_CYC (`RST_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define DEGLITCH_NS 2500
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHOP_CLOCKS 3'h7
`define BLANK_SHORT 3'h3
`define BLANK_LONG 3'h6
`define SEL_SHORT 2'h2
`define SEL_LONG 2'h1
`endif

/* File: design/fault_shutdown_pkg.sv */
// Types for the fault shutdown and blanking controller
package fault_shutdown_pkg;
   typedef enum logic [2:0] {
      ST_STARTUP, ST_RUN, ST_SLEEP, ST_MOTOR_OFF, ST_SHUTDOWN
   } sup_state_type;
endpackage

/* File: design/blank_if.sv */
// Interface between supervisor and blanking timer
`timescale 1ns/100ps
`default_nettype none
interface blank_if;
   logic osc_tick;
   logic [1:0] sel;
   logic reverse;
   logic blanking;
   modport ctrl (output osc_tick, output sel, output reverse, input blanking);
   modport timer (input osc_tick, input sel, input reverse, output blanking);
endinterface
`default_nettype wire

/* File: design/blanking_timer.sv */
// Blanking interval timer for one pair of DC bridges
`timescale 1ns/100ps
`default_nettype none
`include "fault_shutdown_params.svh"
module blanking_timer
   import fault_shutdown_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   blank_if.timer bif
);
   logic [2:0] chop_r, chop_nxt;
   logic [2:0] left_r, left_nxt;

   function automatic logic [2:0] blank_len(input logic [1:0] s);
      if (s == `SEL_SHORT) return `BLANK_SHORT;
      if (s == `SEL_LONG) return `BLANK_LONG;
      return 3'h0;
   endfunction

   always_comb begin
      chop_nxt = chop_r;
      left_nxt = left_r;
      if (bif.osc_tick) begin
         chop_nxt = chop_r + 3'h1;
         if (left_r != 3'h0)
            left_nxt = left_r - 3'h1;
         if (chop_r == `CHOP_CLOCKS)
            left_nxt = blank_len(bif.sel);
      end
      if (bif.reverse)
         left_nxt = blank_len(bif.sel);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         chop_r <= 3'h0;
         left_r <= 3'h0;
      end else begin
         chop_r <= chop_nxt;
         left_r <= left_nxt;
      end
   end

   assign bif.blanking = (left_r != 3'h0);

   chk_reverse_blanks: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      bif.reverse && bif.sel == `SEL_SHORT |=> bif.blanking)
      else $error("reversal did not start blanking");
endmodule
`default_nettype wire

/* File: design/fault_shutdown_blanking_ctrl.sv */
// Fault supervisor, reset output and blanking control
`timescale 1ns/100ps
`default_nettype none
`include "fault_shutdown_params.svh"
module fault_shutdown_blanking_ctrl
   import fault_shutdown_pkg::*;
#(
   parameter int unsigned RST_CYC = `RST_PERIOD_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic motor_oscillator_clock,
   input wire logic all_clear_in,
   input wire logic sleep_request_n,
   input wire logic supply_upper_threshold,
   input wire logic supply_lower_threshold,
   input wire logic supply_power_down,
   input wire logic conv_overcurrent_fault,
   input wire logic conv_overvoltage_fault,
   input wire logic motor_overcurrent_fault,
   input wire logic thermal_shutdown_fault,
   input wire logic [3:0] extended_protection_config,
   input wire logic [1:0] blank_sel_ab,
   input wire logic [1:0] blank_sel_cd,
   input wire logic reverse_ab,
   input wire logic reverse_cd,
   output logic system_reset_out_n,
   output logic conv_enable,
   output logic motor_enable,
   output logic blanking_ab,
   output logic blanking_cd,
   output logic [2:0] sup_state
);
   localparam int unsigned DG_CYC = `DEGLITCH_CYC;

   // Two-flop synchronisers for the oscillator, supply, fault, sleep and all-clear inputs
   logic [10:0] s1_r, s2_r;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         // Sleep comes up at its idle pin level, all-clear comes up asserted
         s1_r <= 11'h005;
         s2_r <= 11'h005;
      end else begin
         s1_r <= {motor_oscillator_clock, supply_upper_threshold,
                  supply_lower_threshold, supply_power_down,
                  conv_overcurrent_fault, conv_overvoltage_fault,
                  motor_overcurrent_fault, thermal_shutdown_fault,
                  sleep_request_n, reverse_ab ^ reverse_cd, all_clear_in};
         s2_r <= s1_r;
      end
   end
   logic osc_s, up_s, lo_s, pd_s, cocp_s, covp_s, mocp_s, tsd_s, slp_s;
   logic ac_s;
   assign {osc_s, up_s, lo_s, pd_s, cocp_s, covp_s, mocp_s, tsd_s, slp_s}
      = s2_r[10:2];
   assign ac_s = s2_r[0];

   // Edge, filter and state registers
   logic osc_d_r, osc_d_nxt, slp_d_r, slp_d_nxt;
   logic ac_f_r, ac_f_nxt;
   logic [7:0] dg_r, dg_nxt;
   logic armed_r, armed_nxt;
   sup_state_type st_r, st_nxt;
   logic [31:0] tm_r, tm_nxt;
   logic rst_n_r, rst_n_nxt;
   logic pulse_r, pulse_nxt;
   logic osc_tick, slp_rise, conv_bad, prot_ok;

   assign osc_tick = osc_s & ~osc_d_r;
   assign slp_rise = slp_s & ~slp_d_r;
   assign prot_ok = (extended_protection_config == 4'h0);
   // Below the upper threshold an armed supply is falling: ignore supervisor
   assign conv_bad = (cocp_s | covp_s) & up_s;

   always_comb begin
      osc_d_nxt = osc_s;
      slp_d_nxt = slp_s;
      ac_f_nxt = ac_f_r;
      dg_nxt = 8'h00;
      if (ac_s != ac_f_r) begin
         dg_nxt = dg_r + 8'h01;
         if (dg_r == 8'(DG_CYC - 1)) begin
            ac_f_nxt = ac_s;
            dg_nxt = 8'h00;
         end
      end
      armed_nxt = armed_r;
      if (up_s)
         armed_nxt = 1'b1;
      else if (!lo_s)
         armed_nxt = 1'b0;
      st_nxt = st_r;
      tm_nxt = (tm_r != 32'h0) ? tm_r - 32'h1 : 32'h0;
      rst_n_nxt = rst_n_r;
      pulse_nxt = pulse_r;
      if (ac_f_r) begin
         st_nxt = ST_STARTUP;
         rst_n_nxt = 1'b0;
         pulse_nxt = 1'b0;
         tm_nxt = 32'(RST_CYC);
         armed_nxt = 1'b0;
      end else begin
         unique case (st_r)
            ST_STARTUP: begin
               if (armed_r && tm_r == 32'h0) begin
                  rst_n_nxt = 1'b1;
                  st_nxt = slp_s ? ST_RUN : ST_SLEEP;
               end
            end
            ST_RUN, ST_SLEEP, ST_MOTOR_OFF: begin
               if (!armed_r) begin
                  st_nxt = ST_STARTUP;
                  rst_n_nxt = 1'b0;
                  tm_nxt = 32'(RST_CYC);
               end else if (prot_ok && (tsd_s || conv_bad)) begin
                  st_nxt = ST_SHUTDOWN;
                  rst_n_nxt = 1'b0;
               end else if (st_r == ST_MOTOR_OFF) begin
                  if (slp_rise || pd_s)
                     st_nxt = ST_RUN;
               end else if (prot_ok && mocp_s) begin
                  st_nxt = ST_MOTOR_OFF;
                  rst_n_nxt = 1'b0;
                  pulse_nxt = 1'b1;
                  tm_nxt = 32'(RST_CYC);
               end else
                  st_nxt = slp_s ? ST_RUN : ST_SLEEP;
               if (pulse_r && tm_r == 32'h0) begin
                  rst_n_nxt = 1'b1;
                  pulse_nxt = 1'b0;
               end
            end
            ST_SHUTDOWN: rst_n_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         osc_d_r <= 1'b0;
         slp_d_r <= 1'b1;
         ac_f_r <= 1'b1;
         dg_r <= 8'h00;
         armed_r <= 1'b0;
         st_r <= ST_STARTUP;
         tm_r <= 32'h0;
         rst_n_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         osc_d_r <= osc_d_nxt;
         slp_d_r <= slp_d_nxt;
         ac_f_r <= ac_f_nxt;
         dg_r <= dg_nxt;
         armed_r <= armed_nxt;
         st_r <= st_nxt;
         tm_r <= tm_nxt;
         rst_n_r <= rst_n_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign system_reset_out_n = rst_n_r;
   assign conv_enable = (st_r == ST_RUN) || (st_r == ST_SLEEP)
                        || (st_r == ST_MOTOR_OFF);
   assign motor_enable = (st_r == ST_RUN);
   assign sup_state = st_r;

   blank_if ab_if ();
   blank_if cd_if ();
   assign ab_if.osc_tick = osc_tick;
   assign ab_if.sel = blank_sel_ab;
   assign ab_if.reverse = reverse_ab;
   assign cd_if.osc_tick = osc_tick;
   assign cd_if.sel = blank_sel_cd;
   assign cd_if.reverse = reverse_cd;
   blanking_timer u_blank_ab (.clk_sys(clk_sys), .sys_rst(sys_rst),
                              .bif(ab_if));
   blanking_timer u_blank_cd (.clk_sys(clk_sys), .sys_rst(sys_rst),
                              .bif(cd_if));
   assign blanking_ab = ab_if.blanking;
   assign blanking_cd = cd_if.blanking;

   chk_shutdown_holds: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      st_r == ST_SHUTDOWN && !ac_f_r |=> st_r == ST_SHUTDOWN)
      else $error("shutdown left without all-clear");
   chk_shutdown_rst_low: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      st_r == ST_SHUTDOWN |-> !system_reset_out_n)
      else $error("reset high during shutdown");
   chk_motor_off_conv: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      st_r == ST_MOTOR_OFF |-> conv_enable && !motor_enable)
      else $error("motor fault state drives wrong enables");
   chk_sleep_outputs: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      st_r == ST_SLEEP |-> !motor_enable && conv_enable)
      else $error("sleep state enables wrong");
   chk_clear_rst_low: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      ac_f_r |=> !system_reset_out_n && st_r == ST_STARTUP)
      else $error("all-clear did not drive reset low");
   chk_prot_masks: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !prot_ok && st_r == ST_RUN && armed_r && !ac_f_r
      |=> st_r != ST_SHUTDOWN)
      else $error("fault acted with protection bits set");
   chk_motor_off_hold: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      st_r == ST_MOTOR_OFF && !slp_rise && !pd_s && armed_r && !ac_f_r
      && !(prot_ok && (tsd_s || conv_bad)) |=> st_r == ST_MOTOR_OFF)
      else $error("motor fault cleared without cause");
   chk_pulse_rise: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      $rose(system_reset_out_n) |-> $past(tm_r) == 32'h0)
      else $error("reset released before period ended");
endmodule
`default_nettype wire

/* File: verif/host_ctrl_model.sv */
// Host controller model: drives sleep and all-clear, watches reset output
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model (
   input wire logic clk_sys,
   input wire logic system_reset_out_n,
   output logic sleep_request_n,
   output logic all_clear_in
);
   int reset_pulses = 0;
   initial begin
      sleep_request_n = 1'b1;
      all_clear_in = 1'b0;
   end
   // Counting falls lets the host tell a retry pulse from a new fault
   always @(negedge system_reset_out_n) reset_pulses++;
   // Toggling sleep is the host's way back from motor-off short of an all-clear restart
   task automatic toggle_sleep(input int low_cyc);
      @(negedge clk_sys);
      sleep_request_n = 1'b0;
      repeat (low_cyc) @(negedge clk_sys);
      sleep_request_n = 1'b1;
   endtask
   task automatic clear_pulse(input int cyc);
      @(negedge clk_sys);
      all_clear_in = 1'b1;
      repeat (cyc) @(negedge clk_sys);
      all_clear_in = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_fault_shutdown_blanking_ctrl.sv */
// Testbench for the fault supervisor and blanking controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
   n_mismatch++; end end
module tb_fault_shutdown_blanking_ctrl import fault_shutdown_pkg::*;;
   localparam int RC = 50;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic osc = 1'b0;
   logic up_th = 1'b1;
   logic lo_th = 1'b1;
   logic pwr_dn = 1'b0;
   logic [3:0] flt = 4'h0;
   logic [3:0] cfg = 4'h0;
   logic [1:0] sel_ab = 2'h0;
   logic [1:0] sel_cd = 2'h0;
   logic rev_ab = 1'b0;
   logic rev_cd = 1'b0;
   logic [2:0] div = 3'h0;
   logic rst_n, conv_en, mot_en, blk_ab, blk_cd, sleep_n, clr;
   logic [2:0] st;
   int n_mismatch = 0;
   int tests_run = 0;
   int ticks = 0;
   int exp_len[$] = '{0, 6, 3, 0};
   fault_shutdown_blanking_ctrl #(.RST_CYC(RC))
      fault_shutdown_blanking_ctrl_i (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .motor_oscillator_clock(osc),
      .all_clear_in(clr), .sleep_request_n(sleep_n),
      .supply_upper_threshold(up_th), .supply_lower_threshold(lo_th),
      .supply_power_down(pwr_dn), .conv_overcurrent_fault(flt[0]),
      .conv_overvoltage_fault(flt[1]), .thermal_shutdown_fault(flt[2]),
      .motor_overcurrent_fault(flt[3]), .extended_protection_config(cfg),
      .blank_sel_ab(sel_ab), .blank_sel_cd(sel_cd), .reverse_ab(rev_ab),
      .reverse_cd(rev_cd), .system_reset_out_n(rst_n), .conv_enable(conv_en),
      .motor_enable(mot_en), .blanking_ab(blk_ab), .blanking_cd(blk_cd),
      .sup_state(st));
   host_ctrl_model host_ctrl_model_i (.clk_sys(clk_sys),
      .system_reset_out_n(rst_n), .sleep_request_n(sleep_n),
      .all_clear_in(clr));
   always #5 clk_sys = ~clk_sys;
   // One oscillator tick every eight system clocks
   always @(negedge clk_sys) begin
      div <= div + 3'h1;
      osc <= div[2];
   end
   always @(posedge osc) ticks++;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic sig(input int k);
      return k == 0 ? rst_n : k == 1 ? blk_ab : k == 2 ? blk_cd : conv_en;
   endfunction
   task automatic await(input int k, input logic v, input int bound,
                        output int el);
      for (el = 1; el <= bound; el++) begin
         @(posedge clk_sys);
         #1;
         if (sig(k) === v) return;
      end
      $display("ERROR wait on signal %0d expected %0h", k, v);
      n_mismatch++;
      finish_test();
   endtask
   task automatic chk3(input logic c, input logic m, input logic r);
      `CHK("conv_enable", c, conv_en)
      `CHK("motor_enable", m, mot_en)
      `CHK("reset_out_n", r, rst_n)
   endtask
   task automatic blank_test(input logic [1:0] s, input bit cd);
      int el, t0;
      @(negedge clk_sys);
      if (cd) sel_cd = s; else sel_ab = s;
      // Reverse just after a chop starts so no chop lands inside the interval
      if (exp_len[s] != 0) await(cd ? 2 : 1, 1'b1, 200, el);
      repeat (8) @(negedge clk_sys);
      if (cd) rev_cd = 1'b1; else rev_ab = 1'b1;
      @(negedge clk_sys);
      rev_ab = 1'b0;
      rev_cd = 1'b0;
      t0 = ticks;
      if (exp_len[s] == 0) begin
         repeat (30) @(negedge clk_sys);
         `CHK("blank_none", 1'b0, sig(cd ? 2 : 1))
         return;
      end
      await(cd ? 2 : 1, 1'b0, 200, el);
      `CHK("blank_len", exp_len[s], ticks - t0)
      t0 = ticks;
      await(cd ? 2 : 1, 1'b1, 200, el);
      `CHK("chop_gap", 1'b1, (ticks - t0) <= 8)
   endtask
   initial begin
      int el, p0;
      void'($urandom(32'h77dcf7b2));
      repeat (3) @(negedge clk_sys);
      sys_rst = 1'b0;
      await(0, 1'b1, 600, el);
      chk3(1, 1, 1);
      `CHK("state", 3'(ST_RUN), st)
      for (int s = 0; s < 4; s++) begin
         blank_test(2'(s), 1'b0);
         blank_test(2'(s), 1'b1);
      end
      cfg = 4'($urandom_range(15, 1));
      flt[3] = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk3(1, 1, 1);
      flt[3] = 1'b0;
      cfg = 4'h0;
      p0 = host_ctrl_model_i.reset_pulses;
      @(negedge clk_sys);
      flt[3] = 1'b1;
      await(0, 1'b0, 10, el);
      chk3(1, 0, 0);
      flt[3] = 1'b0;
      await(0, 1'b1, RC + 10, el);
      `CHK("pulse_len", 1'b1, el >= RC - 2 && el <= RC + 2)
      repeat (3 * RC) @(negedge clk_sys);
      chk3(1, 0, 1);
      `CHK("pulses", p0 + 1, host_ctrl_model_i.reset_pulses)
      fork
         host_ctrl_model_i.toggle_sleep(20);
         begin
            repeat (12) @(negedge clk_sys);
            chk3(1, 0, 1);
         end
      join
      repeat (8) @(negedge clk_sys);
      chk3(1, 1, 1);
      flt[3] = 1'b1;
      repeat (6) @(negedge clk_sys);
      chk3(1, 0, 0);
      flt[3] = 1'b0;
      pwr_dn = 1'b1;
      repeat (6) @(negedge clk_sys);
      pwr_dn = 1'b0;
      `CHK("pd_release", 1'b1, mot_en)
      repeat (RC + 10) @(negedge clk_sys);
      fork
         host_ctrl_model_i.toggle_sleep(20);
         begin
            repeat (12) @(negedge clk_sys);
            `CHK("sleep_state", 3'(ST_SLEEP), st)
            chk3(1, 0, 1);
         end
      join
      repeat (8) @(negedge clk_sys);
      chk3(1, 1, 1);
      for (int k = 0; k < 3; k++) begin
         flt[k] = 1'b1;
         repeat (6) @(negedge clk_sys);
         chk3(0, 0, 0);
         flt[k] = 1'b0;
         repeat (3 * RC) @(negedge clk_sys);
         chk3(0, 0, 0);
         host_ctrl_model_i.clear_pulse(300);
         await(0, 1'b1, 2000, el);
         chk3(1, 1, 1);
      end
      host_ctrl_model_i.clear_pulse(100);
      repeat (10) @(negedge clk_sys);
      `CHK("glitch", 1'b1, rst_n)
      fork
         host_ctrl_model_i.clear_pulse(400);
      join_none
      await(0, 1'b0, 1000, el);
      `CHK("clear_delay", 1'b1, el >= 245 && el <= 1000)
      await(0, 1'b1, 2000, el);
      up_th = 1'b0;
      flt[1] = 1'b1;
      repeat (10) @(negedge clk_sys);
      chk3(1, 1, 1);
      flt[1] = 1'b0;
      lo_th = 1'b0;
      repeat (6) @(negedge clk_sys);
      `CHK("conv_off", 1'b0, conv_en)
      up_th = 1'b1;
      lo_th = 1'b1;
      await(3, 1'b1, 400, el);
      finish_test();
   end
endmodule
`default_nettype wire
